// ### verilog/web_guide_cmd.sv
// remote command decoder of the web guide controller
//
// Contract
// - manual mode: bit 12 rising starts servo centering; zero does nothing.
// - automatic mode: bit 12 rising sets guide point to window middle.
// - bit 12 is never cleared by hardware; keeps last written value.
// - guide point keeps at least 3.175 mm travel on both sides; a window under 6.35 mm pins it to middle.
// - bit 13 gates offset writes; zero ignores them, one applies them.
// - bit 14 rising starts guide point reset: capture web, start timeout.
// - reset commits only if bit 14 returns to zero before timeout.
// - guide point reset honoured only in manual mode with remote bit set; the write returning bit 14 to zero commits whatever its bits 8 and 9.
// - bit 15 selects error polarity: zero standard, one reversed.
// - after reset polarity follows remote bit; local reversal then lost.
// - offset word is signed distance from middle; positive is right.
// - offset step is 0.0635 mm.
// - speed applied only with bit 15 set; value bits 14..8, 0..100.
// - acceleration applied only with bit 7 set; bits 6..0, 0..100.
// - page zero default map; page one puts parameters in words 12, 13.
// - accepted page one shows bits 15 and 14 set in words 12, 13.
// - bit 9 selects manual (zero) or automatic (one) mode.
// - bit 8 gives control to remote controller, else local operator.
`timescale 1ns/10ps
`default_nettype none
module web_guide_cmd #(
  parameter int GP_TIMEOUT_CYC = web_guide_pkg::GP_RESET_TIMEOUT_CYC
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // word writes from the fieldbus process image
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  // word reads into the fieldbus process image
  input wire logic [3:0] rd_idx_i,
  output logic [15:0] rd_data_o,
  // guide state
  input wire logic signed [15:0] web_pos_i,
  input wire logic [14:0] half_span_i,
  // local operator polarity setting
  input wire logic local_pol_we_i,
  input wire logic local_pol_i,
  // decoded outputs
  output logic remote_ctrl_o,
  output logic auto_mode_o,
  output logic servo_center_o,
  output logic signed [15:0] guide_point_o,
  output logic gp_reset_busy_o,
  output logic gp_reset_done_o,
  output logic polarity_rev_o,
  output logic [6:0] speed_o,
  output logic [6:0] accel_o,
  output logic page_o,
  output logic page_ack_o
);

  // ==========================================================
  // write decode
  logic wr_cmd;
  logic wr_offset;
  logic wr_speed;
  logic wr_accel;
  logic wr_page;

  assign wr_cmd = wr_en_i && (wr_idx_i == web_guide_pkg::IDX_COMMAND);
  assign wr_offset = wr_en_i && (wr_idx_i == web_guide_pkg::IDX_OFFSET);
  assign wr_speed = wr_en_i && (wr_idx_i == web_guide_pkg::IDX_SPEED);
  assign wr_accel = wr_en_i && (wr_idx_i == web_guide_pkg::IDX_ACCEL);
  assign wr_page = wr_en_i && (wr_idx_i == web_guide_pkg::IDX_PAGE);

  // ==========================================================
  // stored words, read back as written
  logic [15:0] cmd_q;
  logic [15:0] offset_q;
  logic [15:0] speed_word_q;
  logic [15:0] accel_word_q;
  logic [15:0] page_word_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_q <= web_guide_pkg::RST_WORD;
    end else if (wr_cmd) begin
      cmd_q <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      offset_q <= web_guide_pkg::RST_WORD;
      speed_word_q <= web_guide_pkg::RST_WORD;
      accel_word_q <= web_guide_pkg::RST_WORD;
      page_word_q <= web_guide_pkg::RST_WORD;
    end else begin
      if (wr_offset) begin
        offset_q <= wr_data_i;
      end
      if (wr_speed) begin
        speed_word_q <= wr_data_i;
      end
      if (wr_accel) begin
        accel_word_q <= wr_data_i;
      end
      if (wr_page) begin
        page_word_q <= wr_data_i;
      end
    end
  end

  // ==========================================================
  // mode bits
  logic remote;
  logic auto_mode;

  assign remote = cmd_q[web_guide_pkg::BIT_REMOTE];
  assign auto_mode = cmd_q[web_guide_pkg::BIT_AUTO];
  assign remote_ctrl_o = remote;
  assign auto_mode_o = auto_mode;

  // mode for the write itself: the new word decides what bit 12 means
  logic new_remote;
  logic new_auto;

  assign new_remote = wr_data_i[web_guide_pkg::BIT_REMOTE];
  assign new_auto = wr_data_i[web_guide_pkg::BIT_AUTO];

  // ==========================================================
  // momentary edges on bits 12 and 14
  logic [1:0] mom_old;
  logic [1:0] mom_new;
  logic [1:0] mom_rise;
  logic [1:0] mom_fall;

  assign mom_old = {cmd_q[web_guide_pkg::BIT_GP_RESET],
                    cmd_q[web_guide_pkg::BIT_CENTER]};
  assign mom_new = {wr_data_i[web_guide_pkg::BIT_GP_RESET],
                    wr_data_i[web_guide_pkg::BIT_CENTER]};

  momentary_edge #(
    .WIDTH(2)
  ) u_edge (
    .strobe_i(wr_cmd),
    .old_i(mom_old),
    .new_i(mom_new),
    .rise_o(mom_rise),
    .fall_o(mom_fall)
  );

  logic center_rise;
  logic center_act;
  logic gp_reset_rise;
  logic gp_reset_fall;

  // relies on the controller clearing bit 12 between actions
  assign center_rise = mom_rise[0];
  assign gp_reset_rise = mom_rise[1];
  assign gp_reset_fall = mom_fall[1];
  // local operator owns the guide unless remote bit is set
  assign center_act = center_rise && new_remote;

  // ==========================================================
  // servo centering in manual mode
  logic servo_center_q;

  // start centering once per rising bit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      servo_center_q <= 1'b0;
    end else begin
      servo_center_q <= center_act && !new_auto;
    end
  end

  assign servo_center_o = servo_center_q;

  // ==========================================================
  // guide point reset handshake
  web_guide_pkg::gp_state_t gp_state_q;
  logic [31:0] gp_timer_q;
  logic signed [15:0] gp_capture_q;
  logic gp_commit;
  logic gp_start;
  logic gp_expired;

  // manual mode with remote control only
  assign gp_start = gp_reset_rise && new_remote && !new_auto;
  assign gp_expired = (gp_timer_q == 32'h0000_0000);
  // commit on return to zero before the timeout
  assign gp_commit = (gp_state_q == web_guide_pkg::GP_ARMED) &&
                     gp_reset_fall && !gp_expired;

  // capture web position and arm the timeout
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gp_state_q <= web_guide_pkg::GP_IDLE;
      gp_timer_q <= 32'h0000_0000;
      gp_capture_q <= 16'sh0000;
    end else begin
      case (gp_state_q)
        web_guide_pkg::GP_IDLE: begin
          if (gp_start) begin
            gp_state_q <= web_guide_pkg::GP_ARMED;
            gp_timer_q <= 32'(GP_TIMEOUT_CYC);
            gp_capture_q <= web_pos_i;
          end
        end
        web_guide_pkg::GP_ARMED: begin
          // timeout, or lost authority while bit 14 stays set, discards the change
          if (gp_commit || gp_expired) begin
            gp_state_q <= web_guide_pkg::GP_IDLE;
          end else if (wr_cmd && (!new_remote || new_auto)) begin
            gp_state_q <= web_guide_pkg::GP_IDLE;
          end else begin
            gp_timer_q <= gp_timer_q - 32'h0000_0001;
          end
        end
        default: begin
          gp_state_q <= web_guide_pkg::GP_IDLE;
        end
      endcase
    end
  end

  assign gp_reset_busy_o = (gp_state_q == web_guide_pkg::GP_ARMED);

  logic gp_done_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gp_done_q <= 1'b0;
    end else begin
      gp_done_q <= gp_commit;
    end
  end

  assign gp_reset_done_o = gp_done_q;

  // ==========================================================
  // guide point
  logic gross_en;
  logic offset_apply;
  logic signed [15:0] gp_request;
  logic signed [15:0] gp_limited;
  logic signed [15:0] guide_point_q;

  assign gross_en = cmd_q[web_guide_pkg::BIT_GROSS_EN];
  assign offset_apply = wr_offset && gross_en;

  // signed distance from middle, positive to the right
  assign gp_request = gp_commit ? gp_capture_q : signed'(wr_data_i);

  // keep travel margin on both sides
  guide_point_clamp u_clamp (
    .req_i(gp_request),
    .half_span_i(half_span_i),
    .point_o(gp_limited)
  );

  // point held in 0.0635 mm steps, same unit as offset word
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      guide_point_q <= 16'sh0000;
    end else if (center_act && new_auto) begin
      guide_point_q <= 16'sh0000;
    end else if (gp_commit || offset_apply) begin
      guide_point_q <= gp_limited;
    end
  end

  assign guide_point_o = guide_point_q;

  // ==========================================================
  // error polarity
  logic polarity_q;

  // reset takes the remote bit, which powers up as zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      polarity_q <= 1'b0;
    end else if (wr_cmd) begin
      polarity_q <= wr_data_i[web_guide_pkg::BIT_POLARITY];
    end else if (local_pol_we_i && !remote) begin
      // local setting lives only until the next command word write or reset
      polarity_q <= local_pol_i;
    end
  end

  assign polarity_rev_o = polarity_q;

  // ==========================================================
  // actuator speed and acceleration
  logic [6:0] speed_q;
  logic [6:0] accel_q;
  logic [6:0] speed_val;
  logic [6:0] accel_val;

  assign speed_val = wr_data_i[web_guide_pkg::SPEED_LSB +: 7];
  assign accel_val = wr_data_i[web_guide_pkg::ACCEL_LSB +: 7];

  // out-of-range values are dropped rather than saturated
  // speed gated by bit 15
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_q <= web_guide_pkg::RST_SPEED;
    end else if (wr_speed && wr_data_i[web_guide_pkg::BIT_SPEED_EN] &&
                 speed_val <= web_guide_pkg::PARAM_MAX) begin
      speed_q <= speed_val;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      accel_q <= web_guide_pkg::RST_ACCEL;
    end else if (wr_accel && wr_data_i[web_guide_pkg::BIT_ACCEL_EN] &&
                 accel_val <= web_guide_pkg::PARAM_MAX) begin
      accel_q <= accel_val;
    end
  end

  assign speed_o = speed_q;
  assign accel_o = accel_q;

  // ==========================================================
  // output map page
  logic page_q;
  logic page_ack_q;

  // only pages zero and one are accepted
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_q <= 1'b0;
      page_ack_q <= 1'b0;
    end else if (wr_page) begin
      if (wr_data_i == web_guide_pkg::PAGE_WEB_GUIDE) begin
        page_q <= 1'b1;
        page_ack_q <= 1'b1;
      end else if (wr_data_i == web_guide_pkg::PAGE_DEFAULT) begin
        page_q <= 1'b0;
        page_ack_q <= 1'b0;
      end
    end
  end

  assign page_o = page_q;
  assign page_ack_o = page_ack_q;

  // ==========================================================
  // read back
  logic [15:0] status_a;
  logic [15:0] status_b;

  // acceptance marker in bits 15 and 14
  always_comb begin
    if (page_ack_q) begin
      status_a = {web_guide_pkg::PAGE_ACK_MARK, speed_q, accel_q};
      status_b = {web_guide_pkg::PAGE_ACK_MARK, guide_point_q[13:0]};
    end else begin
      status_a = web_guide_pkg::RST_WORD;
      status_b = web_guide_pkg::RST_WORD;
    end
  end

  logic [15:0] rd_data_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_q <= web_guide_pkg::RST_WORD;
    end else begin
      case (rd_idx_i)
        web_guide_pkg::IDX_COMMAND: rd_data_q <= cmd_q;
        web_guide_pkg::IDX_OFFSET: rd_data_q <= offset_q;
        web_guide_pkg::IDX_SPEED: rd_data_q <= speed_word_q;
        web_guide_pkg::IDX_ACCEL: rd_data_q <= accel_word_q;
        web_guide_pkg::IDX_PAGE: rd_data_q <= page_word_q;
        web_guide_pkg::IDX_STATUS_A: rd_data_q <= status_a;
        web_guide_pkg::IDX_STATUS_B: rd_data_q <= status_b;
        default: rd_data_q <= web_guide_pkg::RST_WORD;
      endcase
    end
  end

  assign rd_data_o = rd_data_q;

endmodule
`default_nettype wire

// ### verilog/web_guide_pkg.sv
// constants shared by the web guide remote command decoder
package web_guide_pkg;

  // ==========================================================
  // process image word indices (writes from the controller)
  localparam logic [3:0] IDX_COMMAND = 4'h0;
  localparam logic [3:0] IDX_OFFSET = 4'h1;
  localparam logic [3:0] IDX_SPEED = 4'h2;
  localparam logic [3:0] IDX_ACCEL = 4'h3;
  localparam logic [3:0] IDX_PAGE = 4'h4;
  // status words read back by the controller
  localparam logic [3:0] IDX_STATUS_A = 4'hC;
  localparam logic [3:0] IDX_STATUS_B = 4'hD;

  // ==========================================================
  // command word fields
  localparam int BIT_REMOTE = 8;
  localparam int BIT_AUTO = 9;
  localparam int BIT_CENTER = 12;
  localparam int BIT_GROSS_EN = 13;
  localparam int BIT_GP_RESET = 14;
  localparam int BIT_POLARITY = 15;

  // speed word: enable in bit 15, value in bits 14..8
  localparam int BIT_SPEED_EN = 15;
  localparam int SPEED_LSB = 8;
  // acceleration word: enable in bit 7, value in bits 6..0
  localparam int BIT_ACCEL_EN = 7;
  localparam int ACCEL_LSB = 0;
  localparam logic [6:0] PARAM_MAX = 7'h64;

  // page select values
  localparam logic [15:0] PAGE_DEFAULT = 16'h0000;
  localparam logic [15:0] PAGE_WEB_GUIDE = 16'h0001;
  // accepted-page marker in bits 15 and 14 of the status words
  localparam logic [1:0] PAGE_ACK_MARK = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [6:0] RST_SPEED = 7'h32;
  localparam logic [6:0] RST_ACCEL = 7'h32;

  // ==========================================================
  // distances: one offset step is 0.0635 mm = 63500 nm
  localparam int OFFSET_LSB_NM = 63500;
  localparam int MARGIN_NM = 3175000;
  // least margin rounds up to whole steps
  localparam logic [15:0] MARGIN_STEPS =
    16'((MARGIN_NM + OFFSET_LSB_NM - 1) / OFFSET_LSB_NM);

  // ==========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int GP_RESET_TIMEOUT_MS = 5000;
  // longest time rounds down
  localparam int GP_RESET_TIMEOUT_CYC =
    (GP_RESET_TIMEOUT_MS * (CLK_HZ / 1000));

  typedef enum logic {
    GP_IDLE,
    GP_ARMED
  } gp_state_t;

endpackage

// ### verilog/momentary_edge.sv
// zero-to-one and one-to-zero detector for momentary command bits across word writes
`timescale 1ns/10ps
`default_nettype none
module momentary_edge #(
  parameter int WIDTH = 4
) (
  input wire logic strobe_i,
  input wire logic [WIDTH-1:0] old_i,
  input wire logic [WIDTH-1:0] new_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  // held ones give no edge, so a bit left at one acts once
  assign rise_o = strobe_i ? (new_i & ~old_i) : '0;
  assign fall_o = strobe_i ? (old_i & ~new_i) : '0;

endmodule
`default_nettype wire

// ### verilog/guide_point_clamp.sv
// limits a requested guide point to keep travel margin on both sides
`timescale 1ns/10ps
`default_nettype none
module guide_point_clamp (
  input wire logic signed [15:0] req_i,
  input wire logic [14:0] half_span_i,
  output logic signed [15:0] point_o
);

  logic signed [15:0] limit;

  // a window narrower than twice the margin pins the point to middle
  always_comb begin
    if ({1'b0, half_span_i} > web_guide_pkg::MARGIN_STEPS) begin
      limit = signed'({1'b0, half_span_i} - web_guide_pkg::MARGIN_STEPS);
    end else begin
      limit = 16'sh0000;
    end
  end

  always_comb begin
    if (req_i > limit) begin
      point_o = limit;
    end else if (req_i < -limit) begin
      point_o = -limit;
    end else begin
      point_o = req_i;
    end
  end

endmodule
`default_nettype wire

// ### sim/web_guide_cmd_properties.sv
// concurrent checks on the ports of the web guide command decoder
`timescale 1ns/10ps
`default_nettype none
module web_guide_cmd_properties #(
  parameter int GP_TIMEOUT_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic remote_ctrl_o,
  input wire logic auto_mode_o,
  input wire logic servo_center_o,
  input wire logic signed [15:0] guide_point_o,
  input wire logic gp_reset_busy_o,
  input wire logic gp_reset_done_o,
  input wire logic polarity_rev_o,
  input wire logic [6:0] speed_o,
  input wire logic [6:0] accel_o,
  input wire logic page_o,
  input wire logic page_ack_o
);
  // ==========================================================
  // helper state
  logic cw, c_rise, g_rise;
  logic [15:0] cmd_q;
  int unsigned busy_cnt_q;
  assign cw = wr_en_i && (wr_idx_i == web_guide_pkg::IDX_COMMAND);
  assign c_rise = cw && wr_data_i[12] && !cmd_q[12] && wr_data_i[8];
  assign g_rise = cw && wr_data_i[14] && !cmd_q[14] && wr_data_i[8];
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_q <= 16'h0000;
    end else if (cw) begin
      cmd_q <= wr_data_i;
    end
  end
  // busy spans too long for a repetition, so count it here
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= gp_reset_busy_o ? busy_cnt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // properties
  property p_center;
    c_rise && !wr_data_i[9] |=> servo_center_o;
  endproperty
  a_center: assert property (p_center) else $error("no centering");
  property p_cause;
    servo_center_o |-> $past(c_rise) && !$past(wr_data_i[9]);
  endproperty
  a_cause: assert property (p_cause) else $error("stray centering");
  property p_mid;
    c_rise && wr_data_i[9] |=> guide_point_o == 16'sh0000;
  endproperty
  a_mid: assert property (p_mid) else $error("guide not middle");
  property p_gate;
    wr_en_i && wr_idx_i == web_guide_pkg::IDX_OFFSET && !cmd_q[13]
      |=> $stable(guide_point_o);
  endproperty
  a_gate: assert property (p_gate) else $error("offset applied");
  property p_mode;
    cw |=> remote_ctrl_o == $past(wr_data_i[8]) &&
      auto_mode_o == $past(wr_data_i[9]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits");
  property p_pol;
    cw |=> polarity_rev_o == $past(wr_data_i[15]);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");
  property p_spd;
    wr_en_i && wr_idx_i == web_guide_pkg::IDX_SPEED && !wr_data_i[15]
      |=> $stable(speed_o);
  endproperty
  a_spd: assert property (p_spd) else $error("speed changed");
  property p_acc;
    wr_en_i && wr_idx_i == web_guide_pkg::IDX_ACCEL && wr_data_i[7] &&
      wr_data_i[6:0] <= 7'h64 |=> accel_o == $past(wr_data_i[6:0]);
  endproperty
  a_acc: assert property (p_acc) else $error("accel not taken");
  property p_arm;
    g_rise && !wr_data_i[9] |=> gp_reset_busy_o;
  endproperty
  a_arm: assert property (p_arm) else $error("reset not armed");
  property p_only;
    $rose(gp_reset_busy_o) |-> remote_ctrl_o && !auto_mode_o;
  endproperty
  a_only: assert property (p_only) else $error("reset armed wrongly");
  property p_done;
    gp_reset_done_o |-> $past(gp_reset_busy_o) && $past(cw) &&
      !$past(wr_data_i[14]) && !gp_reset_busy_o;
  endproperty
  a_done: assert property (p_done) else $error("bad commit");
  property p_tmo;
    busy_cnt_q <= GP_TIMEOUT_CYC + 1;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout overrun");
  property p_page;
    wr_en_i && wr_idx_i == web_guide_pkg::IDX_PAGE &&
      wr_data_i == web_guide_pkg::PAGE_WEB_GUIDE |=> page_o && page_ack_o;
  endproperty
  a_page: assert property (p_page) else $error("no page");
  c_center: cover property (servo_center_o);
  c_done: cover property (gp_reset_done_o);
  c_page: cover property (page_ack_o);
endmodule
bind web_guide_cmd web_guide_cmd_properties #(
  .GP_TIMEOUT_CYC(GP_TIMEOUT_CYC)
) chk (.*);
`default_nettype wire

// ### sim/plc_model.sv
// fieldbus controller model writing process image words
`timescale 1ns/10ps
`default_nettype none
module plc_model (
  input wire logic mclk_i,
  output logic wr_en_o,
  output logic [3:0] wr_idx_o,
  output logic [15:0] wr_data_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_idx_o = 4'h0;
    wr_data_o = 16'h0000;
  end
  // one word per strobe, held across the sampling edge
  task automatic put(input logic [3:0] idx, input logic [15:0] data);
    @(negedge mclk_i);
    wr_en_o = 1'b1;
    wr_idx_o = idx;
    wr_data_o = data;
    @(negedge mclk_i);
    wr_en_o = 1'b0;
    // released bus must not look like the last word
    wr_idx_o = ~idx;
    wr_data_o = ~data;
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench of the web guide remote command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  $display("wrong value %s exp %0h got %0h", n, e, s); err_total++; end end
module tb;
  logic mclk_i = 1'b0;
  logic arst_n_i, wr_en_i, local_pol_we_i, local_pol_i;
  logic [3:0] wr_idx_i, rd_idx_i;
  logic [15:0] wr_data_i, rd_data_o;
  logic signed [15:0] web_pos_i, guide_point_o;
  logic [14:0] half_span_i;
  logic remote_ctrl_o, auto_mode_o, servo_center_o, polarity_rev_o;
  logic gp_reset_busy_o, gp_reset_done_o, page_o, page_ack_o;
  logic [6:0] speed_o, accel_o;
  int err_total = 0;
  int cmp_count = 0;
  always #20 mclk_i = ~mclk_i;
  plc_model plc (
    .mclk_i(mclk_i),
    .wr_en_o(wr_en_i),
    .wr_idx_o(wr_idx_i),
    .wr_data_o(wr_data_i)
  );
  web_guide_cmd #(.GP_TIMEOUT_CYC(20)) uut (.*);
  // ==========================================================
  // shared tasks
  task automatic conclude;
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset;
    arst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    arst_n_i = 1'b1;
  endtask
  task automatic rd(input logic [3:0] idx, input logic [15:0] e);
    rd_idx_i = idx;
    @(negedge mclk_i);
    `CHK("read", e, rd_data_o)
  endtask
  // ==========================================================
  // scenarios
  task automatic t_pol;
    `CHK("speed rst", 7'h32, speed_o)
    plc.put(4'h0, 16'h8100);
    `CHK("pol rev", 1'b1, polarity_rev_o)
    local_pol_i = 1'b0;
    local_pol_we_i = 1'b1;
    @(negedge mclk_i);
    local_pol_we_i = 1'b0;
    `CHK("pol remote", 1'b1, polarity_rev_o)
    plc.put(4'h0, 16'h0000);
    `CHK("pol std", 1'b0, polarity_rev_o)
    local_pol_i = 1'b1;
    local_pol_we_i = 1'b1;
    @(negedge mclk_i);
    local_pol_we_i = 1'b0;
    `CHK("pol local", 1'b1, polarity_rev_o)
    do_reset;
    `CHK("pol power", 1'b0, polarity_rev_o)
  endtask
  task automatic t_center;
    plc.put(4'h0, 16'h0100);
    `CHK("remote", 1'b1, remote_ctrl_o)
    `CHK("auto", 1'b0, auto_mode_o)
    plc.put(4'h0, 16'h1100);
    `CHK("center", 1'b1, servo_center_o)
    @(negedge mclk_i);
    `CHK("center end", 1'b0, servo_center_o)
    plc.put(4'h0, 16'h1100);
    `CHK("center held", 1'b0, servo_center_o)
    rd(4'h0, 16'h1100);
    plc.put(4'h0, 16'h0100);
    `CHK("center zero", 1'b0, servo_center_o)
  endtask
  task automatic t_auto;
    half_span_i = 15'h00C8;
    plc.put(4'h0, 16'h2300);
    plc.put(4'h1, 16'h0064);
    `CHK("gp right", 16'h0064, guide_point_o)
    plc.put(4'h1, 16'hFC18);
    `CHK("gp left", 16'hFF6A, guide_point_o)
    plc.put(4'h1, 16'h7FFF);
    `CHK("gp max", 16'h0096, guide_point_o)
    half_span_i = 15'h0033;
    plc.put(4'h1, 16'h0010);
    `CHK("gp narrow", 16'h0001, guide_point_o)
    half_span_i = 15'h00C8;
    plc.put(4'h0, 16'h3300);
    `CHK("gp mid", 16'h0000, guide_point_o)
    plc.put(4'h0, 16'h0300);
    plc.put(4'h1, 16'h0010);
    `CHK("gp gated", 16'h0000, guide_point_o)
  endtask
  task automatic t_gpres;
    web_pos_i = 16'h0028;
    plc.put(4'h0, 16'h0100);
    plc.put(4'h0, 16'h4100);
    `CHK("busy", 1'b1, gp_reset_busy_o)
    plc.put(4'h0, 16'h0100);
    `CHK("done", 1'b1, gp_reset_done_o)
    `CHK("gp web", 16'h0028, guide_point_o)
    web_pos_i = 16'hFFE2;
    plc.put(4'h0, 16'h4100);
    repeat (25) @(negedge mclk_i);
    `CHK("expired", 1'b0, gp_reset_busy_o)
    plc.put(4'h0, 16'h0100);
    `CHK("gp kept", 16'h0028, guide_point_o)
    plc.put(4'h0, 16'h4300);
    `CHK("auto refused", 1'b0, gp_reset_busy_o)
    plc.put(4'h0, 16'h0000);
    plc.put(4'h0, 16'h4000);
    `CHK("local refused", 1'b0, gp_reset_busy_o)
  endtask
  task automatic t_param;
    logic [15:0] sw [4] = '{16'h0A00, 16'h8000, 16'hE400, 16'hE500};
    logic [6:0] se [4] = '{7'h32, 7'h00, 7'h64, 7'h64};
    for (int i = 0; i < 4; i++) begin
      plc.put(4'h2, sw[i]);
      `CHK("speed", se[i], speed_o)
      plc.put(4'h3, {8'h00, sw[i][15:8]});
      `CHK("accel", se[i], accel_o)
    end
  endtask
  task automatic t_page;
    rd(4'hC, 16'h0000);
    plc.put(4'h4, 16'h0001);
    `CHK("page", 1'b1, page_o)
    `CHK("ack", 1'b1, page_ack_o)
    rd(4'hC, {2'b11, 7'h64, 7'h64});
    rd(4'hD, {2'b11, 14'h0028});
    rd(4'h7, 16'h0000);
    plc.put(4'h4, 16'h0005);
    `CHK("page odd", 1'b1, page_o)
    plc.put(4'h4, 16'h0000);
    `CHK("page zero", 1'b0, page_ack_o)
    rd(4'hD, 16'h0000);
  endtask
  initial begin
    rd_idx_i = 4'h0;
    web_pos_i = 16'h0000;
    half_span_i = 15'h00C8;
    local_pol_we_i = 1'b0;
    local_pol_i = 1'b0;
    do_reset;
    t_pol;
    t_center;
    t_auto;
    t_gpres;
    t_param;
    t_page;
    conclude;
  end
  // whole run needs some 100 cycles
  initial begin
    #100000;
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
